// [src/isc_pkg.sv]
/*
 Shared constants and types of the serial register-access slave.
 Assumes a register file that answers a word address combinationally.
*/
package isc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [2:0] TX_BIT_LAST = 3'h7;
   localparam logic [1:0] BYTE_COMMIT = 2'h2;
   localparam logic [1:0] BYTE_LAST = 2'h3;
   localparam logic [1:0] BYTE_ALIGN = 2'h0;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic [6:0] SLV_ADDR_DEF = 7'h0A;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_RACK = 3'h3,
      ST_TX = 3'h2,
      ST_TACK = 3'h6,
      ST_WAIT = 3'h4
   } isc_state_e;

   typedef enum logic [1:0] {
      K_CTRL = 2'h0,
      K_ADDR = 2'h1,
      K_DATA = 2'h2
   } isc_kind_e;

   typedef struct packed {
      logic rd_cap;
      logic rd_done;
      logic wr;
      logic [ADDR_W+1:0] addr;
      logic [DATA_W-1:0] wdata;
   } isc_csr_req_s;
endpackage

// [src/isc_slave.sv]
/*
 Serial two-wire slave that reads and writes 32-bit system registers.
 Assumes scl and sda arrive asynchronously and are idle high, and that
 the register file answers csr_rdata from csr_req.addr in the same cycle.
*/
// Overview of operation
// - Capture whole register into a holding copy before shifting each read.
// - Pulse read side effect only when master acks third output byte.
// - Fourth byte comes from the captured copy, not the cleared register.
// - Nack or start or stop before third ack means no side effect.
// - In multiple reads each register gets its own side effect pulse.
// - Register file defers live events arriving after capture until done.
// - Acknowledge every data byte of a write sequence.
// - Single register write leaves the address pointer unchanged.
// - Multiple write advances the pointer per register, wrapping at maximum.
// - Final register of a multiple access also increments the pointer.
// - Unexpected start or stop abandons the transfer at once.
// - Write a register only after all 32 bits arrived.
// - With direction zero the next byte loads the address pointer.
// - Byte address is word address with two zero bits; MSB first.
// - Ack on fourth read byte increments pointer and sends next register.
`timescale 1ns/1ps
module isc_slave #(
   parameter logic [6:0] SLV_ADDR = isc_pkg::SLV_ADDR_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output isc_pkg::isc_csr_req_s csr_req,
   input wire logic [isc_pkg::DATA_W-1:0] csr_rdata
);
   import isc_pkg::*;

   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic scl_rise, scl_fall, start_ev, stop_ev;

   isc_state_e st_reg, st_next;
   isc_kind_e kind_reg, kind_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [1:0] bidx_reg, bidx_next;
   logic multi_reg, multi_next;
   logic pend_inc_reg, pend_inc_next;
   logic inc_ack_reg, inc_ack_next;
   logic rw_reg, rw_next;
   logic ackd_reg, ackd_next;
   logic cap_pend_reg, cap_pend_next;
   logic oe_reg, oe_next;
   logic [7:0] sr_reg, sr_next;
   logic [DATA_W-1:0] wbuf_reg, wbuf_next;
   logic [DATA_W-1:0] shadow_reg, shadow_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic [ADDR_W-1:0] ptr_reg, ptr_next;
   logic rd_cap_reg, rd_cap_next;
   logic rd_done_reg, rd_done_next;
   logic wr_reg, wr_next;

   if (SLV_ADDR == 7'h00) begin : g_chk
      $error("isc_slave: general call address cannot be the slave address");
   end

   // Two-stage synchronisers, then a delayed copy for edge detection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_s1 <= LINE_IDLE;
         scl_s2 <= LINE_IDLE;
         scl_d <= LINE_IDLE;
         sda_s1 <= LINE_IDLE;
         sda_s2 <= LINE_IDLE;
         sda_d <= LINE_IDLE;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;

   always_comb begin
      st_next = st_reg;
      kind_next = kind_reg;
      cnt_next = cnt_reg;
      bidx_next = bidx_reg;
      multi_next = multi_reg;
      pend_inc_next = pend_inc_reg;
      inc_ack_next = inc_ack_reg;
      rw_next = rw_reg;
      ackd_next = ackd_reg;
      cap_pend_next = 1'b0;
      oe_next = oe_reg;
      sr_next = sr_reg;
      wbuf_next = wbuf_reg;
      shadow_next = shadow_reg;
      wdata_next = wdata_reg;
      ptr_next = ptr_reg;
      rd_cap_next = 1'b0;
      rd_done_next = 1'b0;
      wr_next = 1'b0;
      if (cap_pend_reg) begin
         // Freeze the word; side effects wait for the third ack
         shadow_next = csr_rdata;
         rd_cap_next = 1'b1;
         oe_next = ~csr_rdata[DATA_W-1];
      end
      if (start_ev) begin
         // Abandon anything in flight; nothing is written or committed
         st_next = ST_RX;
         kind_next = K_CTRL;
         cnt_next = 4'h0;
         oe_next = 1'b0;
         cap_pend_next = 1'b0;
         rd_cap_next = 1'b0;
      end else if (stop_ev) begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
         cap_pend_next = 1'b0;
         rd_cap_next = 1'b0;
      end else begin
         case (st_reg)
            ST_RX: begin
               if (scl_rise) begin
                  sr_next = {sr_reg[6:0], sda_s2};
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == 4'h1 && kind_reg == K_DATA
                  && pend_inc_reg) begin
                  // Stop and start also raise scl; step only on a real bit
                  ptr_next = ptr_reg + 1'b1;
                  pend_inc_next = 1'b0;
               end else if (scl_fall && cnt_reg == BIT_CNT_FULL) begin
                  cnt_next = 4'h0;
                  st_next = ST_RACK;
                  oe_next = 1'b1;
                  case (kind_reg)
                     K_CTRL: begin
                        rw_next = sr_reg[0];
                        if (sr_reg[7:1] != SLV_ADDR) begin
                           st_next = ST_WAIT;
                           oe_next = 1'b0;
                        end
                     end
                     K_ADDR: begin
                        ptr_next = sr_reg;
                     end
                     default: begin
                        wbuf_next = {wbuf_reg[DATA_W-9:0], sr_reg};
                        if (bidx_reg == BYTE_LAST) begin
                           // Only a full word reaches the register file
                           wr_next = 1'b1;
                           wdata_next = {wbuf_reg[DATA_W-9:0], sr_reg};
                           bidx_next = BYTE_ALIGN;
                           inc_ack_next = multi_reg;
                           pend_inc_next = ~multi_reg;
                           multi_next = 1'b1;
                        end else begin
                           bidx_next = bidx_reg + 2'h1;
                        end
                     end
                  endcase
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  oe_next = 1'b0;
                  st_next = ST_RX;
                  if (inc_ack_reg) begin
                     ptr_next = ptr_reg + 1'b1;
                  end
                  inc_ack_next = 1'b0;
                  if (kind_reg == K_CTRL && rw_reg) begin
                     st_next = ST_TX;
                     cap_pend_next = 1'b1;
                     bidx_next = BYTE_ALIGN;
                     multi_next = 1'b0;
                  end else if (kind_reg == K_CTRL) begin
                     kind_next = K_ADDR;
                  end else if (kind_reg == K_ADDR) begin
                     kind_next = K_DATA;
                     bidx_next = BYTE_ALIGN;
                     multi_next = 1'b0;
                     pend_inc_next = 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  // Shift only the held copy, never live contents
                  shadow_next = {shadow_reg[DATA_W-2:0], 1'b0};
                  cnt_next = cnt_reg + 4'h1;
                  oe_next = ~shadow_reg[DATA_W-2];
                  if (cnt_reg[2:0] == TX_BIT_LAST) begin
                     st_next = ST_TACK;
                     oe_next = 1'b0;
                     cnt_next = 4'h0;
                  end
               end
            end
            ST_TACK: begin
               if (scl_rise) begin
                  ackd_next = ~sda_s2;
                  if (~sda_s2 && bidx_reg == BYTE_COMMIT) begin
                     rd_done_next = 1'b1;
                  end
               end else if (scl_fall) begin
                  if (ackd_reg) begin
                     st_next = ST_TX;
                     if (bidx_reg == BYTE_LAST) begin
                        ptr_next = ptr_reg + 1'b1;
                        multi_next = 1'b1;
                        bidx_next = BYTE_ALIGN;
                        cap_pend_next = 1'b1;
                     end else begin
                        bidx_next = bidx_reg + 2'h1;
                        oe_next = ~shadow_reg[DATA_W-1];
                     end
                  end else begin
                     st_next = ST_WAIT;
                     if (bidx_reg == BYTE_LAST && multi_reg) begin
                        ptr_next = ptr_reg + 1'b1;
                     end
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= ST_IDLE;
         kind_reg <= K_CTRL;
         cnt_reg <= 4'h0;
         bidx_reg <= 2'h0;
         multi_reg <= 1'b0;
         pend_inc_reg <= 1'b0;
         inc_ack_reg <= 1'b0;
         rw_reg <= 1'b0;
         ackd_reg <= 1'b0;
         cap_pend_reg <= 1'b0;
         oe_reg <= 1'b0;
         sr_reg <= 8'h00;
         wbuf_reg <= 32'h00000000;
         shadow_reg <= 32'h00000000;
         wdata_reg <= 32'h00000000;
         ptr_reg <= 8'h00;
         rd_cap_reg <= 1'b0;
         rd_done_reg <= 1'b0;
         wr_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         kind_reg <= kind_next;
         cnt_reg <= cnt_next;
         bidx_reg <= bidx_next;
         multi_reg <= multi_next;
         pend_inc_reg <= pend_inc_next;
         inc_ack_reg <= inc_ack_next;
         rw_reg <= rw_next;
         ackd_reg <= ackd_next;
         cap_pend_reg <= cap_pend_next;
         oe_reg <= oe_next;
         sr_reg <= sr_next;
         wbuf_reg <= wbuf_next;
         shadow_reg <= shadow_next;
         wdata_reg <= wdata_next;
         ptr_reg <= ptr_next;
         rd_cap_reg <= rd_cap_next;
         rd_done_reg <= rd_done_next;
         wr_reg <= wr_next;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe = oe_reg;
   assign csr_req.rd_cap = rd_cap_reg;
   assign csr_req.rd_done = rd_done_reg;
   assign csr_req.wr = wr_reg;
   assign csr_req.addr = {ptr_reg, 2'b00};
   assign csr_req.wdata = wdata_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_capture;
      cap_pend_reg ##1 rd_cap_reg;
   endsequence

   AST_CAPTURE_WORD: assert property (
      (cap_pend_reg && !start_ev && !stop_ev) |-> s_capture
         and (##1 shadow_reg == $past(csr_rdata)))
      else $error("read word not captured before shifting");

   AST_COMMIT_THIRD_ACK: assert property (
      rd_done_reg |-> $past(st_reg == ST_TACK && bidx_reg == BYTE_COMMIT
         && scl_rise && !sda_s2))
      else $error("side effect pulse without third byte ack");

   AST_SHADOW_HELD: assert property (
      (st_reg == ST_TACK && !cap_pend_reg) |=> $stable(shadow_reg))
      else $error("held read word changed between bytes");

   AST_NO_COMMIT_AFTER_START: assert property (
      start_ev |=> !rd_done_reg ##1 !rd_done_reg)
      else $error("side effect after start condition");

   AST_ACK_DATA: assert property (
      (st_reg == ST_RX && kind_reg == K_DATA && scl_fall
         && cnt_reg == BIT_CNT_FULL && !start_ev && !stop_ev)
      |=> (sda_oe && st_reg == ST_RACK))
      else $error("data byte not acknowledged");

   AST_WRITE_FULL_WORD: assert property (
      wr_reg |-> $past(st_reg == ST_RX && bidx_reg == BYTE_LAST
         && kind_reg == K_DATA))
      else $error("write issued before four bytes");

   AST_WRITE_PTR_STEP: assert property (
      (st_reg == ST_RACK && inc_ack_reg && scl_fall && !start_ev
         && !stop_ev) |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("pointer not advanced in multiple write");

   AST_ADDR_LOAD: assert property (
      (st_reg == ST_RX && kind_reg == K_ADDR && scl_fall
         && cnt_reg == BIT_CNT_FULL && !start_ev && !stop_ev)
      |=> ptr_reg == $past(sr_reg))
      else $error("address byte not loaded into pointer");

   AST_READ_NEXT: assert property (
      (st_reg == ST_TACK && ackd_reg && bidx_reg == BYTE_LAST && scl_fall
         && !start_ev && !stop_ev)
      |=> (ptr_reg == $past(ptr_reg) + 8'h01) ##1 rd_cap_reg)
      else $error("acked fourth byte did not start next register");

   AST_STOP_RELEASE: assert property (
      stop_ev |=> (!sda_oe && st_reg == ST_IDLE))
      else $error("line still driven after stop");
endmodule

// [test/isc_host.sv]
/*
 Behavioural bus master that faces the serial register slave.
 Assumes a pull-up on the data wire, resolved by the bench.
*/
`timescale 1ns/1ps
module isc_host (
   input wire logic clk,
   output logic scl,
   output logic sda_pull,
   input wire logic sda_in
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // One 80 ns bit: data set early in low phase, read late in high phase
   task automatic bit_io(input logic b, output logic r);
      repeat (2) @(posedge clk);
      sda_pull <= ~b;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (2) @(posedge clk);
      r = sda_in;
      scl <= 1'b0;
   endtask
   task automatic start_c();
      sda_pull <= 1'b0;
      repeat (6) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda_pull <= 1'b1;
      repeat (4) @(posedge clk);
      scl <= 1'b0;
   endtask
   // Stop after any byte, even part-way through a word, or to end a read
   task automatic stop_c();
      sda_pull <= 1'b1;
      repeat (6) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda_pull <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // Bytes leave MSB first; only used words are written
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Ack on a fourth byte asks for the next word
   task automatic recv(output logic [7:0] d, input logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(~ack, r);
   endtask
endmodule

// [test/tb_i2c_slave_csr_access.sv]
/*
 Self-checking bench of the serial register slave.
 Assumes the host model and a word register file kept here.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin \
   comparisons++; \
   if ((a) !== (e)) begin \
      error_cnt++; \
      $display("[FAIL] %0t got %h want %h", $time, (a), (e)); \
   end \
end
module tb_i2c_slave_csr_access;
   import isc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic scl;
   logic host_pull;
   logic sda;
   logic sda_o;
   logic sda_oe;
   isc_csr_req_s csr_req;
   logic [DATA_W-1:0] csr_rdata;
   logic [DATA_W-1:0] regs [0:255];
   int error_cnt = 0;
   int comparisons = 0;
   int wr_cnt = 0;
   int done_cnt = 0;
   int cap_cnt = 0;
   logic ack;
   logic [7:0] b;

   always #5 clk = ~clk;
   // Open-drain wire with pull-up
   assign sda = (host_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
   assign csr_rdata = regs[csr_req.addr[ADDR_W+1:2]];

   isc_slave u_isc_slave (
      .clk(clk),
      .nrst(nrst),
      .scl_i(scl),
      .sda_i(sda),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .csr_req(csr_req),
      .csr_rdata(csr_rdata)
   );
   isc_host u_isc_host (
      .clk(clk),
      .scl(scl),
      .sda_pull(host_pull),
      .sda_in(sda)
   );

   // Register file; words 0x10 and 0x11 clear at the read indication
   always @(posedge clk) begin
      if (csr_req.wr === 1'b1) begin
         regs[csr_req.addr[ADDR_W+1:2]] <= csr_req.wdata;
         wr_cnt++;
      end
      if (csr_req.rd_cap === 1'b1)
         cap_cnt++;
      if (csr_req.rd_done === 1'b1) begin
         done_cnt++;
         if (csr_req.addr[ADDR_W+1:3] === 7'h08)
            regs[csr_req.addr[ADDR_W+1:2]] <= 32'h0;
      end
   end

   task automatic hdr(input logic rw);
      u_isc_host.start_c();
      u_isc_host.send({SLV_ADDR_DEF, rw}, ack);
      `CHK(ack, 1'b1)
   endtask
   task automatic set_ptr(input logic [7:0] a);
      hdr(1'b0);
      u_isc_host.send(a, ack);
      `CHK(ack, 1'b1)
   endtask
   task automatic wr_words(input logic [7:0] a, input int n,
                           input logic [31:0] w);
      logic [31:0] v;
      set_ptr(a);
      for (int k = 0; k < 4 * n; k++) begin
         v = w + 32'(k / 4);
         u_isc_host.send(v[31 - 8 * (k % 4) -: 8], ack);
         `CHK(ack, 1'b1)
      end
      u_isc_host.stop_c();
   endtask
   task automatic rd_words(input int n, input logic [31:0] e0,
                           input logic [31:0] e1);
      logic [31:0] v;
      hdr(1'b1);
      for (int k = 0; k < 4 * n; k++) begin
         u_isc_host.recv(b, k != 4 * n - 1);
         v = {v[23:0], b};
         if (k % 4 == 3)
            `CHK(v, (k < 4) ? e0 : e1)
      end
      u_isc_host.stop_c();
   endtask

   task automatic t_single();
      wr_words(8'h12, 1, 32'hA1B2C3D4);
      `CHK(regs[8'h12], 32'hA1B2C3D4)
      `CHK(csr_req.addr, 10'h048)
      rd_words(1, 32'hA1B2C3D4, 32'h0);
      rd_words(1, 32'hA1B2C3D4, 32'h0);
   endtask
   task automatic t_multi();
      regs[8'h01] = 32'h5A5A0001;
      wr_words(8'hFF, 2, 32'h11110000);
      `CHK(regs[8'hFF], 32'h11110000)
      `CHK(regs[8'h00], 32'h11110001)
      `CHK(csr_req.addr, 10'h004)
      rd_words(1, 32'h5A5A0001, 32'h0);
   endtask
   task automatic t_abort();
      int w0;
      regs[8'h20] = 32'h0000BEEF;
      w0 = wr_cnt;
      set_ptr(8'h20);
      for (int k = 0; k < 3; k++)
         u_isc_host.send(8'h55, ack);
      u_isc_host.start_c();
      u_isc_host.send({7'h0B, 1'b0}, ack);
      `CHK(ack, 1'b0)
      u_isc_host.stop_c();
      set_ptr(8'h20);
      u_isc_host.send(8'h66, ack);
      u_isc_host.stop_c();
      `CHK(regs[8'h20], 32'h0000BEEF)
      `CHK(wr_cnt, w0)
      wr_words(8'h21, 1, 32'h01020304);
      `CHK(regs[8'h21], 32'h01020304)
   endtask
   task automatic t_cor();
      int n0;
      int c0;
      regs[8'h10] = 32'h800000F1;
      regs[8'h11] = 32'h00000F02;
      n0 = done_cnt;
      c0 = cap_cnt;
      set_ptr(8'h10);
      u_isc_host.stop_c();
      rd_words(2, 32'h800000F1, 32'h00000F02);
      `CHK(regs[8'h10], 32'h0)
      `CHK(regs[8'h11], 32'h0)
      `CHK(done_cnt - n0, 2)
      `CHK(cap_cnt - c0, 2)
   endtask
   task automatic t_invalid();
      int n0;
      int c0;
      regs[8'h10] = 32'h00000077;
      n0 = done_cnt;
      c0 = cap_cnt;
      set_ptr(8'h10);
      u_isc_host.stop_c();
      for (int j = 1; j <= 3; j++) begin
         hdr(1'b1);
         for (int k = 1; k <= j; k++)
            u_isc_host.recv(b, k != j);
         u_isc_host.stop_c();
      end
      `CHK(regs[8'h10], 32'h00000077)
      `CHK(done_cnt, n0)
      `CHK(cap_cnt - c0, 3)
   endtask

   task automatic wrap_up();
      $display("Checks %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      t_single();
      t_multi();
      t_abort();
      t_cor();
      t_invalid();
      wrap_up();
   end
   initial begin
      #400us;
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule
